/* File: src/sop_regs.vh */
// register map, reset values, field layout and access codes for the serial pin control
`ifndef SOP_REGS_VH
`define SOP_REGS_VH

// --------------------------------------------------------------------------
// bus access sizes
// --------------------------------------------------------------------------
`define SOP_SZ_BIT 2'h0
`define SOP_SZ_BYTE 2'h1
`define SOP_SZ_WORD 2'h2

// --------------------------------------------------------------------------
// register addresses (byte address of the low byte)
// --------------------------------------------------------------------------
`define SOP_ADDR_SE0 20'hF0120
`define SOP_ADDR_SS0 20'hF0122
`define SOP_ADDR_ST0 20'hF0124
`define SOP_ADDR_SO0 20'hF0128
`define SOP_ADDR_SERIAL_OUTPUT_GATE_U0 20'hF012A
`define SOP_ADDR_TX_LEVEL_INVERT_U0 20'hF0134
`define SOP_ADDR_SE1 20'hF0160
`define SOP_ADDR_SS1 20'hF0162
`define SOP_ADDR_ST1 20'hF0164
`define SOP_ADDR_SO1 20'hF0168
`define SOP_ADDR_SERIAL_OUTPUT_GATE_U1 20'hF016A
`define SOP_ADDR_TX_LEVEL_INVERT_U1 20'hF0174

// --------------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------------
`define SOP_RST_SO0 16'h0F0F
`define SOP_RST_SO1 16'h0303
`define SOP_RST_ZERO 16'h0000
`define SOP_RST_PIN 1'b1

// --------------------------------------------------------------------------
// implemented bit masks (other bits hold their reset value)
// --------------------------------------------------------------------------
`define SOP_MASK_SO0 16'h090D
`define SOP_MASK_SO1 16'h0101
`define SOP_MASK_CH0 16'h000F
`define SOP_MASK_CH1 16'h0003
`define SOP_MASK_SERIAL_OUTPUT_GATE_U0 16'h000D
`define SOP_MASK_SERIAL_OUTPUT_GATE_U1 16'h0001
`define SOP_MASK_TX_LEVEL_INVERT_U0 16'h0005
`define SOP_MASK_TX_LEVEL_INVERT_U1 16'h0001

// --------------------------------------------------------------------------
// field layout
// --------------------------------------------------------------------------
`define SOP_CKO_LSB 8
`define SOP_NCH 6
`define SOP_NCH_U0 4

`endif

/* File: src/sop_pin_cell.v */
// one channel's registered serial data and clock pin drivers
`timescale 1ns/10ps
`include "sop_regs.vh"

module sop_pin_cell (
  input wire clk_i,
  input wire rst_i,
  input wire data_bit_i,   // stored data output bit
  input wire clock_bit_i,  // stored clock output bit
  input wire out_en_i,     // output enable bit
  input wire invert_i,     // inversion bit
  output reg so_pin_o,
  output reg sck_pin_o
);

  // --------------------------------------------------------------------------
  // pin registers
  // --------------------------------------------------------------------------
  // inversion only reaches the pin while output is enabled, so a software
  // waveform on a gated-off channel is never flipped
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      so_pin_o <= `SOP_RST_PIN;
      sck_pin_o <= `SOP_RST_PIN;
    end else begin
      so_pin_o <= data_bit_i ^ (out_en_i & invert_i);
      sck_pin_o <= clock_bit_i;
    end
  end

endmodule // sop_pin_cell

/* File: src/sop_top.v */
// serial output pin control: output gate, pin level buffer and level invert registers
//
// Functional notes
// - gate off: pin follows software data bit
// - gate on: software data writes ignored
// - clock bit writable only while channel stopped
// - data and clock bits drive their pins
// - gate register resets zero; word/byte/bit writes
// - gate bit 0 stops, 1 enables comm output
// - buffer resets 0F0F (unit0), 0303 (unit1)
// - buffer writes word-only; unit0 bit layout
// - inversion reaches pin only when gated on
// - inversion bit 1 inverts comm data
// - invert register resets zero; word/byte writes
// - start sets, stop clears channel enable status
`timescale 1ns/10ps
`include "sop_regs.vh"

module sop_top (
  input wire clk_i,
  input wire rst_i,
  input wire [19:0] bus_addr_i,   // byte address of the access
  input wire bus_wr_i,            // write strobe, one cycle
  input wire bus_rd_i,            // read strobe, one cycle
  input wire [1:0] bus_size_i,    // bit, byte or word access
  input wire [2:0] bus_bit_i,     // bit index for bit accesses
  input wire [15:0] bus_wdata_i,  // write data; bit access uses bit 0
  output reg [15:0] bus_rdata_o,  // read data, valid the cycle after bus_rd_i
  input wire [5:0] comm_data_i,   // data level from the shifting engines
  input wire [5:0] comm_data_we_i,
  input wire [5:0] comm_clk_i,    // clock level from the shifting engines
  input wire [5:0] comm_clk_we_i,
  output wire [5:0] ch_enable_o,  // channel enable status, to the engines
  output wire [5:0] ch_out_en_o,  // output gate bits, to the engines
  output wire [5:0] so_pin_o,
  output wire [5:0] sck_pin_o
);

  // --------------------------------------------------------------------------
  // merge a bus write into an old value, fixed bits held at their reset value
  // --------------------------------------------------------------------------
  function [15:0] merge;
    input [15:0] old;
    input [1:0] size;
    input [2:0] bitx;
    input [15:0] wdata;
    input [15:0] mask;
    input [15:0] fixed;
    reg [15:0] nv;
    begin
      nv = old;
      case (size)
        `SOP_SZ_WORD: nv = wdata;
        `SOP_SZ_BYTE: nv = {old[15:8], wdata[7:0]};
        `SOP_SZ_BIT: nv[bitx] = wdata[0];
        default: nv = old;
      endcase
      merge = (nv & mask) | (fixed & ~mask);
    end
  endfunction

  // --------------------------------------------------------------------------
  // stored state
  // --------------------------------------------------------------------------
  reg [15:0] so0_q;   // pin level buffer, unit 0
  reg [15:0] so1_q;   // pin level buffer, unit 1
  reg [15:0] serial_output_gate_u0_q;  // output gate, unit 0
  reg [15:0] serial_output_gate_u1_q;  // output gate, unit 1
  reg [15:0] tx_level_invert_u0_q;  // level invert, unit 0
  reg [15:0] tx_level_invert_u1_q;  // level invert, unit 1
  reg [15:0] se0_q;   // channel enable status, unit 0
  reg [15:0] se1_q;   // channel enable status, unit 1

  // --------------------------------------------------------------------------
  // write decode with the access sizes each register accepts
  // --------------------------------------------------------------------------
  wire sz_word = (bus_size_i == `SOP_SZ_WORD);
  wire sz_byte = (bus_size_i == `SOP_SZ_BYTE);
  wire any_size = sz_word | sz_byte | (bus_size_i == `SOP_SZ_BIT);
  wire wr_so0 = bus_wr_i & (bus_addr_i == `SOP_ADDR_SO0) & sz_word;
  wire wr_so1 = bus_wr_i & (bus_addr_i == `SOP_ADDR_SO1) & sz_word;
  wire wr_serial_output_gate_u0 = bus_wr_i & (bus_addr_i == `SOP_ADDR_SERIAL_OUTPUT_GATE_U0) & any_size;
  wire wr_serial_output_gate_u1 = bus_wr_i & (bus_addr_i == `SOP_ADDR_SERIAL_OUTPUT_GATE_U1) & any_size;
  wire wr_tx_level_invert_u0 = bus_wr_i & (bus_addr_i == `SOP_ADDR_TX_LEVEL_INVERT_U0) & (sz_word | sz_byte);
  wire wr_tx_level_invert_u1 = bus_wr_i & (bus_addr_i == `SOP_ADDR_TX_LEVEL_INVERT_U1) & (sz_word | sz_byte);
  wire wr_ss0 = bus_wr_i & (bus_addr_i == `SOP_ADDR_SS0) & any_size;
  wire wr_ss1 = bus_wr_i & (bus_addr_i == `SOP_ADDR_SS1) & any_size;
  wire wr_st0 = bus_wr_i & (bus_addr_i == `SOP_ADDR_ST0) & any_size;
  wire wr_st1 = bus_wr_i & (bus_addr_i == `SOP_ADDR_ST1) & any_size;

  // --------------------------------------------------------------------------
  // software candidate values
  // --------------------------------------------------------------------------
  // reserved gate and invert bits read back zero whatever software writes
  wire [15:0] serial_output_gate_u0_sw = merge(serial_output_gate_u0_q, bus_size_i, bus_bit_i, bus_wdata_i,
                              `SOP_MASK_SERIAL_OUTPUT_GATE_U0, `SOP_RST_ZERO);
  wire [15:0] serial_output_gate_u1_sw = merge(serial_output_gate_u1_q, bus_size_i, bus_bit_i, bus_wdata_i,
                              `SOP_MASK_SERIAL_OUTPUT_GATE_U1, `SOP_RST_ZERO);
  wire [15:0] tx_level_invert_u0_sw = merge(tx_level_invert_u0_q, bus_size_i, bus_bit_i, bus_wdata_i,
                              `SOP_MASK_TX_LEVEL_INVERT_U0, `SOP_RST_ZERO);
  wire [15:0] tx_level_invert_u1_sw = merge(tx_level_invert_u1_q, bus_size_i, bus_bit_i, bus_wdata_i,
                              `SOP_MASK_TX_LEVEL_INVERT_U1, `SOP_RST_ZERO);
  wire [15:0] so0_sw = merge(so0_q, bus_size_i, bus_bit_i, bus_wdata_i,
                             `SOP_MASK_SO0, `SOP_RST_SO0);
  wire [15:0] so1_sw = merge(so1_q, bus_size_i, bus_bit_i, bus_wdata_i,
                             `SOP_MASK_SO1, `SOP_RST_SO1);
  // trigger registers: a written 1 is a one-shot, nothing is stored
  wire [15:0] trig0 = merge(`SOP_RST_ZERO, bus_size_i, bus_bit_i, bus_wdata_i,
                            `SOP_MASK_CH0, `SOP_RST_ZERO);
  wire [15:0] trig1 = merge(`SOP_RST_ZERO, bus_size_i, bus_bit_i, bus_wdata_i,
                            `SOP_MASK_CH1, `SOP_RST_ZERO);

  // --------------------------------------------------------------------------
  // per-channel views of the unit registers
  // --------------------------------------------------------------------------
  wire [5:0] se_v = {se1_q[1:0], se0_q[3:0]};
  wire [5:0] soe_v = {serial_output_gate_u1_q[1:0], serial_output_gate_u0_q[3:0]};
  wire [5:0] sol_v = {tx_level_invert_u1_q[1:0], tx_level_invert_u0_q[3:0]};
  wire [5:0] dat_v = {so1_q[1:0], so0_q[3:0]};
  wire [5:0] cko_v = {so1_q[`SOP_CKO_LSB+1:`SOP_CKO_LSB], so0_q[`SOP_CKO_LSB+3:`SOP_CKO_LSB]};
  wire [5:0] dat_sw = {so1_sw[1:0], so0_sw[3:0]};
  wire [5:0] cko_sw = {so1_sw[`SOP_CKO_LSB+1:`SOP_CKO_LSB],
                       so0_sw[`SOP_CKO_LSB+3:`SOP_CKO_LSB]};
  wire [5:0] so_wr = {{2{wr_so1}}, {4{wr_so0}}};
  wire [5:0] dat_d;   // next data output bits
  wire [5:0] cko_d;   // next clock output bits
  // next gate and invert values: the pin register takes these, so a gate or
  // invert write reaches the pin at the same edge as the register itself
  wire [15:0] serial_output_gate_u0_d = wr_serial_output_gate_u0 ? serial_output_gate_u0_sw : serial_output_gate_u0_q;
  wire [15:0] serial_output_gate_u1_d = wr_serial_output_gate_u1 ? serial_output_gate_u1_sw : serial_output_gate_u1_q;
  wire [15:0] tx_level_invert_u0_d = wr_tx_level_invert_u0 ? tx_level_invert_u0_sw : tx_level_invert_u0_q;
  wire [15:0] tx_level_invert_u1_d = wr_tx_level_invert_u1 ? tx_level_invert_u1_sw : tx_level_invert_u1_q;
  wire [5:0] soe_d = {serial_output_gate_u1_d[1:0], serial_output_gate_u0_d[3:0]};  // next gate bits per channel
  wire [5:0] sol_d = {tx_level_invert_u1_d[1:0], tx_level_invert_u0_d[3:0]};  // next invert bits per channel

  // --------------------------------------------------------------------------
  // per-channel buffer update and pin drivers
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `SOP_NCH; g = g + 1) begin : g_ch
      // gate on: only the engine moves the data bit; gate off: only software
      assign dat_d[g] = soe_v[g] ? (comm_data_we_i[g] ? comm_data_i[g] : dat_v[g])
                                 : (so_wr[g] ? dat_sw[g] : dat_v[g]);
      // running channel: only the engine moves the clock bit
      assign cko_d[g] = se_v[g] ? (comm_clk_we_i[g] ? comm_clk_i[g] : cko_v[g])
                                : (so_wr[g] ? cko_sw[g] : cko_v[g]);
      sop_pin_cell u_pin (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .data_bit_i(dat_d[g]),
        .clock_bit_i(cko_d[g]),
        .out_en_i(soe_d[g]),
        .invert_i(sol_d[g]),
        .so_pin_o(so_pin_o[g]),
        .sck_pin_o(sck_pin_o[g])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // register update
  // --------------------------------------------------------------------------
  // fixed buffer bits come back from the reset value, so a careless word
  // write cannot drop them
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      so0_q <= `SOP_RST_SO0;
      so1_q <= `SOP_RST_SO1;
      serial_output_gate_u0_q <= `SOP_RST_ZERO;
      serial_output_gate_u1_q <= `SOP_RST_ZERO;
      tx_level_invert_u0_q <= `SOP_RST_ZERO;
      tx_level_invert_u1_q <= `SOP_RST_ZERO;
      se0_q <= `SOP_RST_ZERO;
      se1_q <= `SOP_RST_ZERO;
    end else begin
      so0_q <= ({4'h0, cko_d[3:0], 4'h0, dat_d[3:0]} & `SOP_MASK_SO0)
               | (`SOP_RST_SO0 & ~`SOP_MASK_SO0);
      so1_q <= ({6'h00, cko_d[5:4], 6'h00, dat_d[5:4]} & `SOP_MASK_SO1)
               | (`SOP_RST_SO1 & ~`SOP_MASK_SO1);
      if (wr_serial_output_gate_u0) begin
        serial_output_gate_u0_q <= serial_output_gate_u0_sw;
      end
      if (wr_serial_output_gate_u1) begin
        serial_output_gate_u1_q <= serial_output_gate_u1_sw;
      end
      // a running channel is not guarded here: software must stop it first
      if (wr_tx_level_invert_u0) begin
        tx_level_invert_u0_q <= tx_level_invert_u0_sw;
      end
      if (wr_tx_level_invert_u1) begin
        tx_level_invert_u1_q <= tx_level_invert_u1_sw;
      end
      // start sets and stop clears the enable status
      if (wr_ss0) begin
        se0_q <= se0_q | trig0;
      end else if (wr_st0) begin
        se0_q <= se0_q & ~trig0;
      end
      if (wr_ss1) begin
        se1_q <= se1_q | trig1;
      end else if (wr_st1) begin
        se1_q <= se1_q & ~trig1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------------
  // trigger registers and unmapped addresses read zero
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_rdata_o <= `SOP_RST_ZERO;
    end else if (bus_rd_i) begin
      case (bus_addr_i)
        `SOP_ADDR_SE0: bus_rdata_o <= se0_q;
        `SOP_ADDR_SE1: bus_rdata_o <= se1_q;
        `SOP_ADDR_SO0: bus_rdata_o <= so0_q;
        `SOP_ADDR_SO1: bus_rdata_o <= so1_q;
        `SOP_ADDR_SERIAL_OUTPUT_GATE_U0: bus_rdata_o <= serial_output_gate_u0_q;
        `SOP_ADDR_SERIAL_OUTPUT_GATE_U1: bus_rdata_o <= serial_output_gate_u1_q;
        `SOP_ADDR_TX_LEVEL_INVERT_U0: bus_rdata_o <= tx_level_invert_u0_q;
        `SOP_ADDR_TX_LEVEL_INVERT_U1: bus_rdata_o <= tx_level_invert_u1_q;
        default: bus_rdata_o <= `SOP_RST_ZERO;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // status toward the shifting engines
  // --------------------------------------------------------------------------
  assign ch_enable_o = se_v;
  assign ch_out_en_o = soe_v;

endmodule // sop_top

/* File: verification/sop_top_asserts.sv */
// port-level checks for the serial pin control block
`timescale 1ns/10ps
`include "sop_regs.vh"
module sop_top_asserts (
  input wire clk_i,
  input wire rst_i,
  input wire [19:0] bus_addr_i,
  input wire bus_wr_i,
  input wire bus_rd_i,
  input wire [1:0] bus_size_i,
  input wire [2:0] bus_bit_i,
  input wire [15:0] bus_wdata_i,
  input wire [15:0] bus_rdata_o,
  input wire [5:0] comm_data_i,
  input wire [5:0] comm_data_we_i,
  input wire [5:0] comm_clk_i,
  input wire [5:0] comm_clk_we_i,
  input wire [5:0] ch_enable_o,
  input wire [5:0] ch_out_en_o,
  input wire [5:0] so_pin_o,
  input wire [5:0] sck_pin_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // --------------------------------------------------------------------------
  // decode helpers, only channel 0 of unit 0 is watched closely
  // --------------------------------------------------------------------------
  wire so0_wr = bus_wr_i && bus_addr_i == `SOP_ADDR_SO0; // buffer write
  wire word_w = bus_size_i == `SOP_SZ_WORD; // full word access
  reset_pins_a: assert property (disable iff (1'b0) rst_i |-> so_pin_o == 6'h3F &&
    sck_pin_o == 6'h3F && ch_out_en_o == 6'h00) else $error("pins not idle in reset");
  gate_off_data_a: assert property (so0_wr && word_w && !ch_out_en_o[0] |=>
    so_pin_o[0] == $past(bus_wdata_i[0])) else $error("data pin ignores software bit");
  gate_on_hold_a: assert property (so0_wr && ch_out_en_o[0] && !comm_data_we_i[0] |=>
    $stable(so_pin_o[0])) else $error("software changed gated data bit");
  clk_stop_wr_a: assert property (so0_wr && word_w && !ch_enable_o[0] |=>
    sck_pin_o[0] == $past(bus_wdata_i[8])) else $error("clock bit write lost");
  clk_run_hold_a: assert property (so0_wr && ch_enable_o[0] && !comm_clk_we_i[0] |=>
    $stable(sck_pin_o[0])) else $error("clock bit written while running");
  comm_clk_pin_a: assert property (ch_enable_o[0] && comm_clk_we_i[0] |=>
    sck_pin_o[0] == $past(comm_clk_i[0])) else $error("clock pin misses engine level");
  so_word_only_a: assert property (so0_wr && !word_w && !ch_out_en_o[0] |=>
    $stable(so_pin_o[0])) else $error("narrow buffer write took effect");
  gate_bit_wr_a: assert property (bus_wr_i && bus_addr_i == `SOP_ADDR_SERIAL_OUTPUT_GATE_U0 &&
    bus_size_i == `SOP_SZ_BIT && bus_bit_i == 3'h0 |=> ch_out_en_o[0] == $past(bus_wdata_i[0]))
    else $error("gate bit write lost");
  start_set_a: assert property (bus_wr_i && bus_addr_i == `SOP_ADDR_SS0 && word_w &&
    bus_wdata_i[0] |=> ch_enable_o[0]) else $error("start did not enable channel");
  fixed_ch1_a: assert property (so_pin_o[1] && sck_pin_o[1])
    else $error("fixed pins moved");
  cover property (so0_wr && ch_out_en_o[0]);
  cover property (ch_enable_o[0] && comm_clk_we_i[0]);
  cover property (comm_data_we_i[4] && ch_out_en_o[4]);
endmodule // sop_top_asserts
bind sop_top sop_top_asserts chk_i (.clk_i(clk_i), .rst_i(rst_i), .bus_addr_i(bus_addr_i),
  .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_size_i(bus_size_i), .bus_bit_i(bus_bit_i),
  .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .comm_data_i(comm_data_i),
  .comm_data_we_i(comm_data_we_i), .comm_clk_i(comm_clk_i), .comm_clk_we_i(comm_clk_we_i),
  .ch_enable_o(ch_enable_o), .ch_out_en_o(ch_out_en_o), .so_pin_o(so_pin_o),
  .sck_pin_o(sck_pin_o));

/* File: verification/sop_peer.sv */
// shifting engine stand-in that feeds data and clock levels to the pin control
`timescale 1ns/10ps
module sop_peer (
  input wire clk_i,
  output reg [5:0] comm_data_o,
  output reg [5:0] comm_data_we_o,
  output reg [5:0] comm_clk_o,
  output reg [5:0] comm_clk_we_o
);
  reg busy = 1'b0; // a transfer owns the lines
  initial begin
    comm_data_o = 6'h00;
    comm_data_we_o = 6'h00;
    comm_clk_o = 6'h00;
    comm_clk_we_o = 6'h00;
  end
  // idle levels flip each cycle so a stale level can never pass for a real one
  always @(negedge clk_i) begin
    if (!busy) begin
      comm_data_o <= ~comm_data_o;
      comm_clk_o <= ~comm_clk_o;
    end
  end
  // one-cycle update pulse on one channel
  task shift(input [2:0] ch, input d, input c, input dw, input cw);
    begin
      @(posedge clk_i);
      busy = 1'b1;
      @(negedge clk_i);
      comm_data_o[ch] = d;
      comm_clk_o[ch] = c;
      comm_data_we_o[ch] = dw;
      comm_clk_we_o[ch] = cw;
      @(negedge clk_i);
      comm_data_we_o = 6'h00;
      comm_clk_we_o = 6'h00;
      busy = 1'b0;
    end
  endtask
endmodule // sop_peer

/* File: verification/tb_serial_output_pin_control.sv */
// self-checking bench for the serial pin control registers
`timescale 1ns/10ps
`include "sop_regs.vh"
module tb_serial_output_pin_control;
  reg clk_i = 1'b0;
  reg rst_i = 1'b0;
  reg [19:0] bus_addr_i = 20'h00000;
  reg bus_wr_i = 1'b0;
  reg bus_rd_i = 1'b0;
  reg [1:0] bus_size_i = 2'h2;
  reg [2:0] bus_bit_i = 3'h0;
  reg [15:0] bus_wdata_i = 16'h0000;
  wire [15:0] bus_rdata_o;
  wire [5:0] cd, cdw, cc, ccw, ch_enable_o, ch_out_en_o, so_pin_o, sck_pin_o;
  integer n_mismatch = 0;
  integer checks = 0;
  integer i;
  reg [15:0] exp_q[$]; // expected read data, oldest first
  reg [15:0] e;
  reg rd_d = 1'b0;
  reg [31:0] seed = 32'h000063DC;
  always #50 clk_i = ~clk_i;
  sop_top uut (.clk_i(clk_i), .rst_i(rst_i), .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i),
    .bus_rd_i(bus_rd_i), .bus_size_i(bus_size_i), .bus_bit_i(bus_bit_i), .bus_wdata_i(bus_wdata_i),
    .bus_rdata_o(bus_rdata_o), .comm_data_i(cd), .comm_data_we_i(cdw), .comm_clk_i(cc),
    .comm_clk_we_i(ccw), .ch_enable_o(ch_enable_o), .ch_out_en_o(ch_out_en_o),
    .so_pin_o(so_pin_o), .sck_pin_o(sck_pin_o));
  sop_peer peer (.clk_i(clk_i), .comm_data_o(cd), .comm_data_we_o(cdw), .comm_clk_o(cc),
    .comm_clk_we_o(ccw));
  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  task fail(input [15:0] g, input [15:0] x);
    begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task chk(input [5:0] g, input [5:0] x);
    begin
      checks = checks + 1;
      if (g !== x) fail({10'h000, g}, {10'h000, x});
    end
  endtask
  // one-cycle write strobe, inputs move on the falling edge
  task wr(input [19:0] a, input [1:0] s, input [2:0] b, input [15:0] d);
    begin
      @(negedge clk_i);
      bus_addr_i = a;
      bus_size_i = s;
      bus_bit_i = b;
      bus_wdata_i = d;
      bus_wr_i = 1'b1;
      @(negedge clk_i);
      bus_wr_i = 1'b0;
    end
  endtask
  task rd(input [19:0] a, input [15:0] x);
    begin
      @(negedge clk_i);
      bus_addr_i = a;
      bus_size_i = `SOP_SZ_WORD;
      bus_rd_i = 1'b1;
      exp_q.push_back(x);
      @(negedge clk_i);
      bus_rd_i = 1'b0;
    end
  endtask
  // read data is registered at the sampling edge and checked at the next falling edge
  always @(posedge clk_i) rd_d <= bus_rd_i && !rst_i;
  always @(negedge clk_i) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      checks = checks + 1;
      if (bus_rdata_o !== e) fail(bus_rdata_o, e);
    end
  end
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // bound on the whole run
  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch = n_mismatch + 1;
    report_and_stop;
  end
  initial begin
    #1 rst_i = 1'b1; // a real rising edge, so the asynchronous reset acts before the first clock
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    rd(`SOP_ADDR_SO0, `SOP_RST_SO0);
    rd(`SOP_ADDR_SO1, `SOP_RST_SO1);
    rd(`SOP_ADDR_SERIAL_OUTPUT_GATE_U0, 16'h0000);
    rd(`SOP_ADDR_SERIAL_OUTPUT_GATE_U1, 16'h0000);
    rd(`SOP_ADDR_TX_LEVEL_INVERT_U0, 16'h0000);
    rd(`SOP_ADDR_TX_LEVEL_INVERT_U1, 16'h0000);
    rd(20'hF0100, 16'h0000);
    chk(so_pin_o & sck_pin_o, 6'h3F);
    $display("reset values done");
    wr(`SOP_ADDR_SO0, `SOP_SZ_WORD, 3'h0, 16'h0F0E);
    chk(so_pin_o, 6'h3E);
    wr(`SOP_ADDR_SO0, `SOP_SZ_BYTE, 3'h0, 16'h00FF);
    rd(`SOP_ADDR_SO0, 16'h0F0E);
    wr(`SOP_ADDR_SO0, `SOP_SZ_WORD, 3'h0, 16'h0E0E);
    chk(sck_pin_o, 6'h3E);
    wr(`SOP_ADDR_SS0, `SOP_SZ_WORD, 3'h0, 16'h0001);
    rd(`SOP_ADDR_SE0, 16'h0001);
    wr(`SOP_ADDR_SO0, `SOP_SZ_WORD, 3'h0, 16'h0F0F);
    rd(`SOP_ADDR_SO0, 16'h0E0F);
    peer.shift(3'h0, 1'b0, 1'b1, 1'b0, 1'b1);
    chk(sck_pin_o, 6'h3F);
    wr(`SOP_ADDR_ST0, `SOP_SZ_WORD, 3'h0, 16'h0001);
    rd(`SOP_ADDR_SE0, 16'h0000);
    wr(`SOP_ADDR_SO1, `SOP_SZ_WORD, 3'h0, 16'h0202);
    chk(sck_pin_o, 6'h2F);
    rd(`SOP_ADDR_SO1, 16'h0202);
    wr(`SOP_ADDR_SO1, `SOP_SZ_WORD, 3'h0, 16'h0303);
    chk(so_pin_o & sck_pin_o, 6'h3F);
    $display("software pin control done");
    wr(`SOP_ADDR_TX_LEVEL_INVERT_U0, `SOP_SZ_BYTE, 3'h0, 16'h0001); // channel stopped
    chk(so_pin_o, 6'h3F);
    wr(`SOP_ADDR_TX_LEVEL_INVERT_U0, `SOP_SZ_BIT, 3'h2, 16'h0001);
    rd(`SOP_ADDR_TX_LEVEL_INVERT_U0, 16'h0001);
    wr(`SOP_ADDR_SERIAL_OUTPUT_GATE_U0, `SOP_SZ_BIT, 3'h0, 16'h0001);
    chk(so_pin_o, 6'h3E);
    wr(`SOP_ADDR_SO0, `SOP_SZ_WORD, 3'h0, 16'h0F0E);
    rd(`SOP_ADDR_SO0, 16'h0F0F);
    peer.shift(3'h0, 1'b0, 1'b0, 1'b1, 1'b0);
    chk(so_pin_o, 6'h3F);
    rd(`SOP_ADDR_SO0, 16'h0F0E);
    wr(`SOP_ADDR_SERIAL_OUTPUT_GATE_U0, `SOP_SZ_WORD, 3'h0, 16'hFFFF);
    rd(`SOP_ADDR_SERIAL_OUTPUT_GATE_U0, 16'h000D);
    wr(`SOP_ADDR_SERIAL_OUTPUT_GATE_U0, `SOP_SZ_WORD, 3'h0, 16'h0000);
    $display("gate and invert done");
    wr(`SOP_ADDR_SERIAL_OUTPUT_GATE_U1, `SOP_SZ_WORD, 3'h0, 16'h0001);
    for (i = 0; i < 8; i = i + 1) begin
      seed = xs(seed);
      wr(`SOP_ADDR_TX_LEVEL_INVERT_U1, `SOP_SZ_WORD, 3'h0, {15'h0000, seed[1]});
      peer.shift(3'h4, seed[0], 1'b0, 1'b1, 1'b0);
      chk(so_pin_o, {1'b1, seed[0] ^ seed[1], 4'hE});
    end
    $display("random unit 1 traffic done");
    report_and_stop;
  end
endmodule // tb_serial_output_pin_control
